// ---- include/citm_defs.vh ----
// Constants of the instruction tail decoder: bus map, flag layout, codes.
`ifndef CITM_DEFS_VH
`define CITM_DEFS_VH

// ****************************************************************
// Register byte offsets on the Avalon-MM slave
// ****************************************************************
`define CITM_REG_CTRL 6'h00
`define CITM_REG_STATUS 6'h04
`define CITM_REG_ACC 6'h08
`define CITM_REG_XLO 6'h0c
`define CITM_REG_XHI 6'h10
`define CITM_REG_SP 6'h14
`define CITM_REG_FLAGS 6'h18
`define CITM_REG_PC 6'h1c
`define CITM_REG_MADDR 6'h20
`define CITM_REG_MDATA 6'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define CITM_CTRL_RUN 0
`define CITM_CTRL_WAKE 1
`define CITM_STAT_RUN 0
`define CITM_STAT_WAIT 1
`define CITM_STAT_ILL 2
`define CITM_FLG_V 7
`define CITM_FLG_H 4
`define CITM_FLG_I 3
`define CITM_FLG_N 2
`define CITM_FLG_Z 1
`define CITM_FLG_C 0

// ****************************************************************
// Reset values and fixed addresses
// ****************************************************************
`define CITM_RST_SP 16'h00ff
`define CITM_RST_FLG 8'h68
`define CITM_RST_PC 16'h0000
`define CITM_TRAP_VEC 16'hfffc
`define CITM_TRAP_STEPS 3'h7

// ****************************************************************
// Opcodes handled by this block
// ****************************************************************
`define CITM_OP_WAIT 8'h8f
`define CITM_OP_TRAP 8'h83
`define CITM_OP_TAP 8'h84
`define CITM_OP_F2A 8'h85
`define CITM_OP_A2X 8'h97
`define CITM_OP_X2A 8'h9f
`define CITM_OP_S2X 8'h95
`define CITM_OP_X2S 8'h94
`define CITM_OP_PRE 8'h9e

`endif

// ---- core/citm_mem.v ----
// Byte memory with two asynchronous read ports and one write port.
`timescale 1ns/10ps
`default_nettype none

module citm_mem #(
   parameter AW = 8
) (
   // Clock
   input wire clk,
   // Write port
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [7:0] wdata,
   // Read ports
   input wire [AW-1:0] raddr_a,
   output wire [7:0] rdata_a,
   input wire [AW-1:0] raddr_b,
   output wire [7:0] rdata_b
);
   reg [7:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];
endmodule

`default_nettype wire

// ---- core/citm_top.v ----
// CPU tail: wait, test, soft trap, transfers and addressing modes.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "citm_defs.vh"

// Operation
// RQ1 - Wait instruction clears the interrupt mask flag.
// RQ2 - After wait, core idles until an interrupt; wait takes one cycle.
// RQ3 - Test subtracts zero, sets N and Z, clears V, stores nothing.
// RQ4 - Indexed post-increment mode uses H:X then increments H:X.
// RQ5 - Indexed 8-bit offset post-increment adds offset, then increments H:X.
// RQ6 - Direct-to-indexed move reads direct, writes at H:X, increments H:X.
// RQ7 - Indexed-to-direct move reads at H:X, writes direct, increments H:X.
// RQ8 - Immediate-to-direct move writes the immediate byte to a direct one.
// RQ9 - Extended mode fetches address high byte first, then low.
// RQ10 - 16-bit indexed offset fetched high then low, added to H:X.
// RQ11 - Stack 8-bit offset mode adds one offset byte to SP.
// RQ12 - Stack 16-bit offset mode adds a two-byte offset to SP.
// RQ13 - Relative branch adds one signed offset byte to the program counter.
// RQ14 - Soft trap pushes PC, X, A, flags, sets mask, loads vector; 9 cycles.
// RQ15 - Transfers between A, flags, X, and SP to H:X plus or minus one.
module citm_top #(
   parameter AW = 8
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Avalon-MM slave
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // Interrupt request from the surrounding logic
   input wire irq_req,
   // Core status
   output reg cpu_waiting
);
   // ****************************************************************
   // States, kinds and addressing modes
   // ****************************************************************
   localparam [3:0] S_IDLE = 4'h0, S_FETCH = 4'h1, S_FETCH2 = 4'h2;
   localparam [3:0] S_OPER = 4'h3, S_RD = 4'h4, S_WR = 4'h5;
   localparam [3:0] S_REL = 4'h6, S_TRAP = 4'h7, S_WAIT = 4'h8;
   localparam [3:0] S_DLY = 4'h9;
   localparam [3:0] K_ZST = 4'h1, K_LDA = 4'h2, K_CBEQ = 4'h3;
   localparam [3:0] K_MDIX = 4'h4, K_MIXD = 4'h5, K_MIMD = 4'h6;
   localparam [3:0] K_MDD = 4'h7, K_BRA = 4'h8, K_ILL = 4'hf;
   localparam [3:0] AM_DIR = 4'h0, AM_ABS = 4'h1, AM_IX = 4'h2;
   localparam [3:0] AM_IX1 = 4'h3, AM_IXW = 4'h4, AM_SPB = 4'h5;
   localparam [3:0] AM_SPW = 4'h6, AM_IMM = 4'h7, AM_NONE = 4'h8;

   // Returns {kind, mode, operand byte count}.
   function [9:0] decode;
      input pre;
      input [7:0] op;
      begin
         case ({pre, op})
            9'h03d: decode = {K_ZST, AM_DIR, 2'd1};
            9'h06d: decode = {K_ZST, AM_IX1, 2'd1};
            9'h07d: decode = {K_ZST, AM_IX, 2'd0};
            9'h16d: decode = {K_ZST, AM_SPB, 2'd1};
            9'h0a6: decode = {K_LDA, AM_IMM, 2'd1};
            9'h0b6: decode = {K_LDA, AM_DIR, 2'd1};
            9'h0c6: decode = {K_LDA, AM_ABS, 2'd2};
            9'h0d6: decode = {K_LDA, AM_IXW, 2'd2};
            9'h0e6: decode = {K_LDA, AM_IX1, 2'd1};
            9'h0f6: decode = {K_LDA, AM_IX, 2'd0};
            9'h1e6: decode = {K_LDA, AM_SPB, 2'd1};
            9'h1d6: decode = {K_LDA, AM_SPW, 2'd2};
            9'h071: decode = {K_CBEQ, AM_IX, 2'd0};
            9'h061: decode = {K_CBEQ, AM_IX1, 2'd1};
            9'h04e: decode = {K_MDD, AM_NONE, 2'd2};
            9'h05e: decode = {K_MDIX, AM_NONE, 2'd1};
            9'h06e: decode = {K_MIMD, AM_NONE, 2'd2};
            9'h07e: decode = {K_MIXD, AM_NONE, 2'd1};
            9'h020: decode = {K_BRA, AM_NONE, 2'd0};
            default: decode = {K_ILL, AM_NONE, 2'd0};
         endcase
      end
   endfunction

   // Effective address of a memory operand.
   function [15:0] ea_calc;
      input [3:0] am;
      input [15:0] hx;
      input [15:0] sp;
      input [7:0] hi;
      input [7:0] lo;
      begin
         case (am)
            AM_ABS: ea_calc = {hi, lo}; // [RQ9]
            AM_IX: ea_calc = hx; // [RQ4]
            AM_IX1: ea_calc = hx + {8'h00, lo}; // [RQ5]
            AM_IXW: ea_calc = hx + {hi, lo}; // [RQ10]
            AM_SPB: ea_calc = sp + {8'h00, lo}; // [RQ11]
            AM_SPW: ea_calc = sp + {hi, lo}; // [RQ12]
            default: ea_calc = {8'h00, lo};
         endcase
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   reg [3:0] st_q, kind_q, am_q;
   reg [1:0] nb_q;
   reg first_q, eq_q, run_q, ill_q, wake_q;
   reg [2:0] cnt_q;
   reg [7:0] a_q, x_q, h_q, flg_q, b1_q, dst_q, data_q;
   reg [15:0] sp_q, pc_q, ea_q;
   reg [AW-1:0] maddr_q;
   reg irq_s1_q, irq_s2_q;
   reg mem_we;
   reg [AW-1:0] mem_waddr, cpu_raddr;
   reg [7:0] mem_wdata;
   reg [15:0] cpu_ra;
   reg [31:0] rd_mux;
   wire [7:0] cpu_rd, bus_rd;
   wire [15:0] hx = {h_q, x_q};
   wire [15:0] hx_inc = hx + 16'h0001;
   wire [9:0] dec = decode(st_q == S_FETCH2, cpu_rd);
   wire bus_wr = avs_write & ~avs_waitrequest;
   wire [7:0] flg_nz = {1'b0, flg_q[6:3], (cpu_rd[7]), (cpu_rd == 8'h00),
      flg_q[0]};

   citm_mem #(.AW(AW)) u_mem (
      .clk(clk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr_a(cpu_raddr),
      .rdata_a(cpu_rd),
      .raddr_b(maddr_q),
      .rdata_b(bus_rd)
   );

   // ****************************************************************
   // Memory port steering
   // ****************************************************************
   always @* begin
      cpu_ra = pc_q;
      if (st_q == S_RD) begin
         cpu_ra = ea_q;
      end else if (st_q == S_TRAP) begin
         cpu_ra = `CITM_TRAP_VEC + {15'h0000, cnt_q[0]};
      end
      cpu_raddr = cpu_ra[AW-1:0];
      mem_we = 1'b0;
      mem_waddr = ea_q[AW-1:0];
      mem_wdata = data_q;
      if (st_q == S_WR) begin
         mem_we = 1'b1;
      end else if (st_q == S_TRAP && cnt_q <= 3'h4) begin
         mem_we = 1'b1;
         mem_waddr = sp_q[AW-1:0];
         case (cnt_q)
            3'h0: mem_wdata = pc_q[7:0];
            3'h1: mem_wdata = pc_q[15:8];
            3'h2: mem_wdata = x_q;
            3'h3: mem_wdata = a_q;
            default: mem_wdata = flg_q;
         endcase
      end else if (!run_q && bus_wr && avs_address == `CITM_REG_MDATA) begin
         mem_we = 1'b1;
         mem_waddr = maddr_q;
         mem_wdata = avs_writedata[7:0];
      end
   end

   // ****************************************************************
   // Avalon-MM slave: one wait cycle, then answer
   // ****************************************************************
   always @* begin
      case (avs_address)
         `CITM_REG_CTRL: rd_mux = {31'h0, run_q};
         `CITM_REG_STATUS: rd_mux = {24'h0, st_q, 1'b0, ill_q,
            cpu_waiting, run_q};
         `CITM_REG_ACC: rd_mux = {24'h0, a_q};
         `CITM_REG_XLO: rd_mux = {24'h0, x_q};
         `CITM_REG_XHI: rd_mux = {24'h0, h_q};
         `CITM_REG_SP: rd_mux = {16'h0, sp_q};
         `CITM_REG_FLAGS: rd_mux = {24'h0, flg_q};
         `CITM_REG_PC: rd_mux = {16'h0, pc_q};
         `CITM_REG_MADDR: rd_mux = {{(32-AW){1'b0}}, maddr_q};
         `CITM_REG_MDATA: rd_mux = {24'h0, bus_rd};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge clk) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         irq_s1_q <= 1'b0;
         irq_s2_q <= 1'b0;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
         irq_s1_q <= irq_req;
         irq_s2_q <= irq_s1_q;
      end
   end

   // ****************************************************************
   // Execution sequencer
   // ****************************************************************
   always @(posedge clk) begin
      if (!nrst) begin
         st_q <= S_IDLE;
         kind_q <= K_ILL;
         am_q <= AM_NONE;
         nb_q <= 2'd0;
         first_q <= 1'b0;
         eq_q <= 1'b0;
         run_q <= 1'b0;
         ill_q <= 1'b0;
         wake_q <= 1'b0;
         cnt_q <= 3'h0;
         a_q <= 8'h00;
         x_q <= 8'h00;
         h_q <= 8'h00;
         flg_q <= `CITM_RST_FLG;
         b1_q <= 8'h00;
         dst_q <= 8'h00;
         data_q <= 8'h00;
         sp_q <= `CITM_RST_SP;
         pc_q <= `CITM_RST_PC;
         ea_q <= 16'h0000;
         maddr_q <= {AW{1'b0}};
         cpu_waiting <= 1'b0;
      end else begin
         wake_q <= 1'b0;
         if (bus_wr) begin
            case (avs_address)
               `CITM_REG_CTRL: begin
                  run_q <= avs_writedata[`CITM_CTRL_RUN];
                  wake_q <= avs_writedata[`CITM_CTRL_WAKE];
               end
               `CITM_REG_STATUS:
                  if (avs_writedata[`CITM_STAT_ILL]) ill_q <= 1'b0;
               `CITM_REG_MADDR: maddr_q <= avs_writedata[AW-1:0];
               default: ;
            endcase
            if (!run_q) begin
               case (avs_address)
                  `CITM_REG_ACC: a_q <= avs_writedata[7:0];
                  `CITM_REG_XLO: x_q <= avs_writedata[7:0];
                  `CITM_REG_XHI: h_q <= avs_writedata[7:0];
                  `CITM_REG_SP: sp_q <= avs_writedata[15:0];
                  `CITM_REG_FLAGS: flg_q <= avs_writedata[7:0];
                  `CITM_REG_PC: pc_q <= avs_writedata[15:0];
                  default: ;
               endcase
            end
         end
         if (!run_q) begin
            st_q <= S_IDLE;
            cpu_waiting <= 1'b0;
         end else begin
            case (st_q)
               S_IDLE: st_q <= S_FETCH;
               S_FETCH, S_FETCH2: begin
                  pc_q <= pc_q + 16'h0001;
                  st_q <= S_FETCH;
                  kind_q <= dec[9:6];
                  am_q <= dec[5:2];
                  nb_q <= dec[1:0];
                  first_q <= 1'b1;
                  ea_q <= hx;
                  if (st_q == S_FETCH && cpu_rd == `CITM_OP_PRE) begin
                     st_q <= S_FETCH2;
                  end else if (st_q == S_FETCH2 && dec[9:6] == K_ILL) begin
                     ill_q <= 1'b1;
                  end else if (st_q == S_FETCH2 || dec[9:6] != K_ILL) begin
                     if (dec[1:0] != 2'd0) st_q <= S_OPER;
                     else if (dec[9:6] == K_BRA) st_q <= S_REL;
                     else st_q <= S_RD;
                  end else begin
                     case (cpu_rd)
                        `CITM_OP_WAIT: begin
                           flg_q[`CITM_FLG_I] <= 1'b0; // [RQ1]
                           cpu_waiting <= 1'b1;
                           st_q <= S_WAIT; // [RQ2]
                        end
                        `CITM_OP_TRAP: begin
                           cnt_q <= 3'h0;
                           st_q <= S_TRAP; // [RQ14]
                        end
                        `CITM_OP_TAP: begin
                           flg_q <= a_q; // [RQ15]
                           st_q <= S_DLY;
                        end
                        `CITM_OP_F2A: a_q <= flg_q; // [RQ15]
                        `CITM_OP_A2X: x_q <= a_q; // [RQ15]
                        `CITM_OP_X2A: a_q <= x_q; // [RQ15]
                        `CITM_OP_S2X: begin
                           {h_q, x_q} <= sp_q + 16'h0001; // [RQ15]
                           st_q <= S_DLY;
                        end
                        `CITM_OP_X2S: begin
                           sp_q <= hx - 16'h0001; // [RQ15]
                           st_q <= S_DLY;
                        end
                        8'h4d: flg_q <= {1'b0, flg_q[6:3], a_q[7],
                           (a_q == 8'h00), flg_q[0]}; // [RQ3]
                        8'h5d: flg_q <= {1'b0, flg_q[6:3], x_q[7],
                           (x_q == 8'h00), flg_q[0]}; // [RQ3]
                        default: ill_q <= 1'b1;
                     endcase
                  end
               end
               S_OPER: begin
                  pc_q <= pc_q + 16'h0001;
                  first_q <= 1'b0;
                  if (nb_q == 2'd2 && first_q) begin
                     b1_q <= cpu_rd;
                  end else begin
                     st_q <= S_RD;
                     ea_q <= ea_calc(am_q, hx, sp_q,
                        (nb_q == 2'd2) ? b1_q : 8'h00, cpu_rd);
                     case (kind_q)
                        K_MIMD: begin
                           data_q <= b1_q;
                           ea_q <= {8'h00, cpu_rd};
                           st_q <= S_WR; // [RQ8]
                        end
                        K_MDD: begin
                           ea_q <= {8'h00, b1_q};
                           dst_q <= cpu_rd;
                        end
                        K_MIXD: begin
                           ea_q <= hx;
                           dst_q <= cpu_rd;
                        end
                        K_MDIX: ea_q <= {8'h00, cpu_rd};
                        K_LDA: if (am_q == AM_IMM) begin
                           a_q <= cpu_rd;
                           flg_q <= flg_nz;
                           st_q <= S_FETCH;
                        end
                        default: ;
                     endcase
                  end
               end
               S_RD: begin
                  st_q <= S_FETCH;
                  case (kind_q)
                     K_ZST: flg_q <= flg_nz; // [RQ3]
                     K_LDA: begin
                        a_q <= cpu_rd;
                        flg_q <= flg_nz;
                     end
                     K_CBEQ: begin
                        {h_q, x_q} <= hx_inc; // [RQ4] [RQ5]
                        eq_q <= (a_q == cpu_rd);
                        st_q <= S_REL;
                     end
                     K_MDIX: begin
                        data_q <= cpu_rd;
                        ea_q <= hx; // [RQ6]
                        st_q <= S_WR;
                     end
                     default: begin
                        data_q <= cpu_rd;
                        ea_q <= {8'h00, dst_q}; // [RQ7]
                        st_q <= S_WR;
                     end
                  endcase
               end
               S_WR: begin
                  flg_q <= {1'b0, flg_q[6:3], data_q[7],
                     (data_q == 8'h00), flg_q[0]};
                  if (kind_q == K_MDIX || kind_q == K_MIXD) begin
                     {h_q, x_q} <= hx_inc; // [RQ6] [RQ7]
                  end
                  st_q <= S_FETCH;
               end
               S_REL: begin
                  if (kind_q == K_BRA || eq_q) begin
                     pc_q <= pc_q + 16'h0001 +
                        {{8{cpu_rd[7]}}, cpu_rd}; // [RQ13]
                  end else begin
                     pc_q <= pc_q + 16'h0001;
                  end
                  st_q <= S_FETCH;
               end
               S_TRAP: begin
                  cnt_q <= cnt_q + 3'h1;
                  if (cnt_q <= 3'h4) sp_q <= sp_q - 16'h0001; // [RQ14]
                  if (cnt_q == 3'h5) flg_q[`CITM_FLG_I] <= 1'b1; // [RQ14]
                  if (cnt_q == 3'h6) pc_q[15:8] <= cpu_rd; // [RQ14]
                  if (cnt_q == `CITM_TRAP_STEPS) begin
                     pc_q[7:0] <= cpu_rd; // [RQ14]
                     st_q <= S_FETCH;
                  end
               end
               S_WAIT: if (irq_s2_q || wake_q) begin
                  cpu_waiting <= 1'b0;
                  st_q <= S_FETCH; // [RQ2]
               end
               S_DLY: st_q <= S_FETCH;
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// ---- tb/citm_properties.sv ----
// Bus handshake and wait-state properties of the instruction tail block.
`timescale 1ns/10ps
`default_nettype none
module citm_properties #(
   parameter AW = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register bus
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Wait state
   input wire logic irq_req,
   input wire logic cpu_waiting
);
   logic [5:0] irq_hist_q;
   logic [3:0] wr_hist_q;
   logic req_q;
   // Recent wake causes, so a release from the halt can be traced back.
   always @(posedge clk) begin
      if (!nrst) begin
         irq_hist_q <= 6'h00;
         wr_hist_q <= 4'h0;
         req_q <= 1'b0;
      end else begin
         irq_hist_q <= {irq_hist_q[4:0], irq_req};
         wr_hist_q <= {wr_hist_q[2:0], avs_write};
         req_q <= avs_read | avs_write;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_ack_one_cycle: assert property (!avs_waitrequest
      |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_ack_needs_req: assert property ($fell(avs_waitrequest)
      |-> req_q)
      else $error("answer without a request");
   a_ack_prompt: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   a_rdata_holds: assert property (avs_waitrequest
      |-> $stable(avs_readdata))
      else $error("read data moved outside a read answer");
   a_rdata_upper: assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest
      && avs_address > 6'h24 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_irq_wakes: assert property (cpu_waiting && irq_req
      |-> ##[1:6] !cpu_waiting)
      else $error("interrupt did not end the halt");
   a_wake_cause: assert property ($fell(cpu_waiting)
      |-> (|irq_hist_q) || (|wr_hist_q))
      else $error("halt ended without interrupt or bus write");
   c_halt: cover property ($rose(cpu_waiting));
   c_wake: cover property ($fell(cpu_waiting));
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the instruction tail block.
`timescale 1ns/10ps
`default_nettype none
`include "citm_defs.vh"
module tb;
   localparam AW = 8;
   logic clk, nrst, avs_read, avs_write, irq_req;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, rv;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, cpu_waiting;
   int n_fail, n_tests;
   citm_top #(.AW(AW)) u_citm_top (.clk(clk), .nrst(nrst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq_req(irq_req),
      .cpu_waiting(cpu_waiting));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ************************************************************
   // Bus and check tasks
   // ************************************************************
   task automatic summarize;
      $display("%0d checks, %0d mismatches", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("unexpected %s: expected %h, seen %h", what, e, g);
         n_fail++;
      end
   endtask
   // The request stands until the edge that samples waitrequest low.
   task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d);
      int i;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (i == 20) begin
         n_fail++;
         summarize();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input string s, input logic [5:0] a,
      input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(s, e, rv);
   endtask
   task automatic poke(input logic [7:0] a, input logic [7:0] d);
      wr(`CITM_REG_MADDR, {24'h0, a});
      wr(`CITM_REG_MDATA, {24'h0, d});
   endtask
   task automatic mchk(input logic [7:0] a, input logic [7:0] e);
      wr(`CITM_REG_MADDR, {24'h0, a});
      rchk("memory byte", `CITM_REG_MDATA, {24'h0, e});
   endtask
   task automatic waitfor(input logic lvl, input int lim);
      int i;
      for (i = 0; i < lim && cpu_waiting !== lvl; i++) @(posedge clk);
      if (cpu_waiting !== lvl) begin
         n_fail++;
         summarize();
      end
   endtask
   // Loads a program that reaches a wait opcode and runs it to the halt.
   task automatic run(input logic [7:0] pc, input logic [63:0] c,
      input int n);
      int i;
      for (i = 0; i < n; i++) poke(pc + i[7:0], c[8*(n-1-i) +: 8]);
      wr(`CITM_REG_PC, {24'h0, pc});
      wr(`CITM_REG_CTRL, 32'h1);
      waitfor(1'b0, 10);
      waitfor(1'b1, 300);
   endtask
   task automatic ldchk(input logic [63:0] c, input int n,
      input logic [7:0] e);
      run(8'h00, c, n);
      rchk("accumulator", `CITM_REG_ACC, {24'h0, e});
      wr(`CITM_REG_CTRL, 32'h0);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      rchk("acc", `CITM_REG_ACC, 32'h0);
      rchk("index", `CITM_REG_XLO, 32'h0);
      rchk("sp", `CITM_REG_SP, 32'h00ff);
      rchk("flags", `CITM_REG_FLAGS, 32'h68);
      rchk("status", `CITM_REG_STATUS, 32'h0);
      rchk("unmapped", 6'h3c, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_wait;
      run(8'h00, 64'h8f8f, 2);
      rchk("flags", `CITM_REG_FLAGS, 32'h60);
      rchk("pc", `CITM_REG_PC, 32'h1);
      repeat (20) @(posedge clk);
      chk("halted", 32'h1, {31'h0, cpu_waiting});
      @(posedge clk);
      irq_req <= 1'b1;
      @(posedge clk);
      irq_req <= 1'b0;
      waitfor(1'b0, 10);
      waitfor(1'b1, 20);
      rchk("pc", `CITM_REG_PC, 32'h2);
      wr(`CITM_REG_CTRL, 32'h0);
      $display("wait test done");
   endtask
   task automatic t_ill;
      run(8'h00, 64'h318f, 2);
      rchk("status", `CITM_REG_STATUS, 32'h87);
      wr(`CITM_REG_STATUS, 32'h4);
      rchk("status", `CITM_REG_STATUS, 32'h83);
      wr(`CITM_REG_CTRL, 32'h0);
      $display("illegal opcode test done");
   endtask
   task automatic t_test;
      wr(`CITM_REG_FLAGS, 32'he8);
      poke(8'h40, 8'h80);
      ldchk(64'h4d853d408f, 5, 8'h6a);
      rchk("flags", `CITM_REG_FLAGS, 32'h64);
      mchk(8'h40, 8'h80);
      $display("test opcode done");
   endtask
   task automatic t_xfer;
      wr(`CITM_REG_ACC, 32'h7a);
      wr(`CITM_REG_XHI, 32'h12);
      wr(`CITM_REG_SP, 32'h0030);
      ldchk(64'h95979484a6009f8f, 8, 8'h7a);
      rchk("h", `CITM_REG_XHI, 32'h0);
      rchk("x", `CITM_REG_XLO, 32'h7a);
      rchk("sp", `CITM_REG_SP, 32'h0079);
      rchk("flags", `CITM_REG_FLAGS, 32'h72);
      $display("transfer test done");
   endtask
   task automatic t_trap;
      wr(`CITM_REG_SP, 32'h0080);
      wr(`CITM_REG_ACC, 32'h11);
      wr(`CITM_REG_XLO, 32'h22);
      wr(`CITM_REG_FLAGS, 32'h60);
      poke(8'hfc, 8'h00);
      poke(8'hfd, 8'h50);
      poke(8'h50, 8'h85);
      poke(8'h51, 8'h8f);
      run(8'h10, 64'h83, 1);
      rchk("acc", `CITM_REG_ACC, 32'h68);
      rchk("pc", `CITM_REG_PC, 32'h0052);
      rchk("sp", `CITM_REG_SP, 32'h007b);
      wr(`CITM_REG_CTRL, 32'h0);
      mchk(8'h80, 8'h11);
      mchk(8'h7f, 8'h00);
      mchk(8'h7e, 8'h22);
      mchk(8'h7d, 8'h11);
      mchk(8'h7c, 8'h60);
      $display("trap test done");
   endtask
   task automatic t_modes;
      poke(8'hc0, 8'ha1);
      ldchk(64'hc601c08f, 4, 8'ha1);
      wr(`CITM_REG_XHI, 32'h0);
      wr(`CITM_REG_XLO, 32'h10);
      poke(8'h50, 8'hb2);
      ldchk(64'hd601408f, 4, 8'hb2);
      wr(`CITM_REG_SP, 32'h0040);
      poke(8'h45, 8'hc3);
      poke(8'h47, 8'hd4);
      ldchk(64'h9ee6058f, 4, 8'hc3);
      ldchk(64'h9ed601078f, 5, 8'hd4);
      poke(8'h1d, 8'h8f);
      run(8'h20, 64'h20fb, 2);
      rchk("pc", `CITM_REG_PC, 32'h001e);
      wr(`CITM_REG_CTRL, 32'h0);
      wr(`CITM_REG_XLO, 32'h70);
      poke(8'h71, 8'h3c);
      run(8'h00, 64'h6e5a605e607e618f, 8);
      rchk("x", `CITM_REG_XLO, 32'h72);
      wr(`CITM_REG_CTRL, 32'h0);
      mchk(8'h60, 8'h5a);
      mchk(8'h70, 8'h5a);
      mchk(8'h61, 8'h3c);
      wr(`CITM_REG_ACC, 32'ha5);
      wr(`CITM_REG_XLO, 32'h90);
      poke(8'h90, 8'ha5);
      poke(8'ha1, 8'ha5);
      run(8'h00, 64'h71018f6110018f8f, 8);
      rchk("x", `CITM_REG_XLO, 32'h92);
      rchk("pc", `CITM_REG_PC, 32'h0008);
      $display("mode test done");
   endtask
   initial begin
      n_fail = 0;
      n_tests = 0;
      nrst = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      irq_req = 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_wait();
      t_ill();
      t_test();
      t_xfer();
      t_trap();
      t_modes();
      summarize();
   end
endmodule
bind citm_top citm_properties #(.AW(AW)) u_citm_properties (.clk(clk),
   .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .irq_req(irq_req), .cpu_waiting(cpu_waiting));
`default_nettype wire
